// >>> plmd_pkg.sv
// Constants, encodings and types shared by the pointer load and move decoder.
// Assumes a core clock of 100 MHz and four clock quarters per instruction cycle.
package plmd_pkg;

  // ****************************************************************
  // Opcode prefixes and instruction fields
  // ****************************************************************
  localparam logic [5:0] OPC_PTR_HI  = 6'h38;
  localparam logic [7:0] OPC_PTR_LO  = 8'hF0;
  localparam logic [5:0] OPC_RMOV    = 6'h14;
  localparam logic [3:0] OPC_FSM_SRC = 4'hC;
  localparam logic [3:0] OPC_FSM_DST = 4'hF;
  localparam logic [1:0] PTR_BAD_SEL = 2'h3;
  localparam int         DEST_BIT    = 9;
  localparam int         BANK_BIT    = 8;

  // ****************************************************************
  // Addressing
  // ****************************************************************
  localparam logic [7:0] INDEX_LIMIT    = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT   = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam int         INDEX_PTR      = 2;

  // ****************************************************************
  // Instruction cycle quarters
  // ****************************************************************
  localparam logic [1:0] QTR_1 = 2'h0;
  localparam logic [1:0] QTR_2 = 2'h1;
  localparam logic [1:0] QTR_3 = 2'h2;
  localparam logic [1:0] QTR_4 = 2'h3;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_WREG = 12'h004;
  localparam logic [11:0] ADDR_PTR0 = 12'h008;
  localparam logic [11:0] ADDR_PTR1 = 12'h00C;
  localparam logic [11:0] ADDR_PTR2 = 12'h010;
  localparam logic [11:0] ADDR_STAT = 12'h014;
  localparam int          CTRL_EXT_BIT  = 0;
  localparam int          CTRL_BANK_LSB = 8;
  localparam int          STAT_Z_BIT    = 0;
  localparam int          STAT_N_BIT    = 1;
  localparam int          STAT_BUSY_BIT = 2;
  localparam logic        RST_EXT  = 1'b0;
  localparam logic [3:0]  RST_BANK = 4'h0;
  localparam logic [7:0]  RST_WREG = 8'h00;
  localparam logic [11:0] RST_PTR  = 12'h000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_FIRST   = 2'h0,
    ST_PTR_LO  = 2'h1,
    ST_FSM_DST = 2'h2
  } plmd_seq_t;

  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_PTR_HI  = 3'h1,
    OP_PTR_LO  = 3'h2,
    OP_RMOV    = 3'h3,
    OP_FSM_SRC = 3'h4,
    OP_FSM_DST = 3'h5
  } plmd_op_t;

endpackage

// >>> plmd_addr_gen.sv
// Data address former for the register move instruction.
// Assumes all inputs are stable, same-clock values from the decoder.
`timescale 1ns/10ps
`default_nettype none
module plmd_addr_gen (
  input  wire logic [7:0]  reg_sel,
  input  wire logic        bank_bit,
  input  wire logic [3:0]  bank_selector,
  input  wire logic        ext_enable,
  input  wire logic [11:0] index_base,
  output logic      [11:0] data_addr
);

  // ****************************************************************
  // Bank, access or indexed address
  // ****************************************************************
  always_comb begin
    if (bank_bit) begin
      data_addr = {bank_selector, reg_sel};
    end else if (ext_enable && reg_sel <= plmd_pkg::INDEX_LIMIT) begin
      // Wraps inside the 4 KB space, no carry out
      data_addr = index_base + {4'h0, reg_sel};
    end else if (reg_sel < plmd_pkg::ACCESS_SPLIT) begin
      data_addr = {plmd_pkg::ACCESS_LO_BANK, reg_sel};
    end else begin
      data_addr = {plmd_pkg::ACCESS_HI_BANK, reg_sel};
    end
  end

endmodule
`default_nettype wire

// >>> plmd_top.sv
// Decode and execution of pointer literal load, register move and full space move.
// Assumes instruction words and data memory read data on the same clock, memory
// read data valid in the cycle of the read strobe, and an APB master for control.
//
// Functional notes
// - Pointer load: two words, 111000 then F0
// - Pointer load writes 12-bit literal, select 0..2
// - Register move targets working or source register
// - Bank bit picks access bank or bank selector
// - Extended set indexes addresses up to 5F
// - Full space move copies source to destination
// - Source read first cycle, destination written second Q4
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module plmd_top (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic [15:0] instr_word,
  input  wire logic        instr_valid,
  input  wire logic        skip_exec,
  output logic             instr_ack,
  output logic      [11:0] mem_addr,
  output logic             mem_rd,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_wr,
  output logic      [7:0]  mem_wdata,
  output logic      [7:0]  wreg,
  output logic             flag_negative,
  output logic             flag_zero,
  output logic      [11:0] ptr0,
  output logic      [11:0] ptr1,
  output logic      [11:0] ptr2,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0]             q;
    plmd_pkg::plmd_seq_t    st;
    plmd_pkg::plmd_op_t     op;
    logic [15:0]            word;
    logic                   skip;
    logic [1:0]             sel;
    logic [3:0]             lit_hi;
    logic [7:0]             data;
    logic [2:0][11:0]       ptr;
    logic [7:0]             wreg;
    logic                   nf;
    logic                   zf;
    logic                   ext;
    logic [3:0]             bank;
    logic                   instr_ack;
    logic [11:0]            mem_addr;
    logic                   mem_rd;
    logic                   mem_wr;
    logic [7:0]             mem_wdata;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
  } plmd_top_state_t;

  plmd_top_state_t s;
  plmd_top_state_t next_s;
  logic [11:0]     rmov_addr;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic apb_hit(input logic [11:0] a);
    apb_hit = (a == plmd_pkg::ADDR_CTRL) || (a == plmd_pkg::ADDR_WREG) ||
              (a == plmd_pkg::ADDR_PTR0) || (a == plmd_pkg::ADDR_PTR1) ||
              (a == plmd_pkg::ADDR_PTR2) || (a == plmd_pkg::ADDR_STAT);
  endfunction

  function automatic logic [31:0] apb_read(input logic [11:0] a, input plmd_top_state_t c);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      plmd_pkg::ADDR_CTRL: begin
        r[plmd_pkg::CTRL_EXT_BIT] = c.ext;
        r[plmd_pkg::CTRL_BANK_LSB +: 4] = c.bank;
      end
      plmd_pkg::ADDR_WREG: r[7:0] = c.wreg;
      plmd_pkg::ADDR_PTR0: r[11:0] = c.ptr[0];
      plmd_pkg::ADDR_PTR1: r[11:0] = c.ptr[1];
      plmd_pkg::ADDR_PTR2: r[11:0] = c.ptr[2];
      plmd_pkg::ADDR_STAT: begin
        r[plmd_pkg::STAT_Z_BIT] = c.zf;
        r[plmd_pkg::STAT_N_BIT] = c.nf;
        r[plmd_pkg::STAT_BUSY_BIT] = (c.st != plmd_pkg::ST_FIRST);
      end
      default: r = 32'h0000_0000;
    endcase
    apb_read = r;
  endfunction

  plmd_addr_gen u_addr_gen (
    .reg_sel       (instr_word[7:0]),
    .bank_bit      (instr_word[plmd_pkg::BANK_BIT]),
    .bank_selector (s.bank),
    .ext_enable    (s.ext),
    .index_base    (s.ptr[plmd_pkg::INDEX_PTR]),
    .data_addr     (rmov_addr)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.instr_ack = 1'b0;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.q = s.q + 2'h1;

    // No wait state: decoding in the setup cycle keeps prdata and pready straight from flops
    if (psel && !penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = apb_read(paddr, s);
      next_s.pslverr = !apb_hit(paddr);
    end
    if (psel && penable && s.pready && pwrite && apb_hit(paddr)) begin
      if (paddr == plmd_pkg::ADDR_CTRL && pstrb[0]) begin
        next_s.ext = pwdata[plmd_pkg::CTRL_EXT_BIT];
      end
      if (paddr == plmd_pkg::ADDR_CTRL && pstrb[1]) begin
        next_s.bank = pwdata[plmd_pkg::CTRL_BANK_LSB +: 4];
      end
      if (paddr == plmd_pkg::ADDR_WREG && pstrb[0]) begin
        next_s.wreg = pwdata[7:0];
      end
    end

    case (s.q)
      plmd_pkg::QTR_1: begin
        next_s.op = plmd_pkg::OP_NONE;
        // No word offered: the cycle idles and a pending second word still waits
        if (instr_valid) begin
          next_s.instr_ack = 1'b1;
          next_s.word = instr_word;
          case (s.st)
            plmd_pkg::ST_FIRST: begin
              next_s.skip = skip_exec;
              if (instr_word[15:10] == plmd_pkg::OPC_PTR_HI &&
                  instr_word[9:8] != plmd_pkg::PTR_BAD_SEL) begin
                next_s.sel = instr_word[9:8];
                next_s.lit_hi = instr_word[3:0];
                next_s.st = plmd_pkg::ST_PTR_LO;
                if (!skip_exec) begin
                  next_s.op = plmd_pkg::OP_PTR_HI;
                end
              end else if (instr_word[15:10] == plmd_pkg::OPC_RMOV) begin
                if (!skip_exec) begin
                  next_s.op = plmd_pkg::OP_RMOV;
                  next_s.mem_addr = rmov_addr;
                  next_s.mem_rd = 1'b1;
                end
              end else if (instr_word[15:12] == plmd_pkg::OPC_FSM_SRC) begin
                next_s.st = plmd_pkg::ST_FSM_DST;
                if (!skip_exec) begin
                  next_s.op = plmd_pkg::OP_FSM_SRC;
                  next_s.mem_addr = instr_word[11:0];
                  next_s.mem_rd = 1'b1;
                end
              end
            end
            plmd_pkg::ST_PTR_LO: begin
              next_s.st = plmd_pkg::ST_FIRST;
              if (instr_word[15:8] == plmd_pkg::OPC_PTR_LO && !s.skip) begin
                next_s.op = plmd_pkg::OP_PTR_LO;
              end
            end
            plmd_pkg::ST_FSM_DST: begin
              next_s.st = plmd_pkg::ST_FIRST;
              if (instr_word[15:12] == plmd_pkg::OPC_FSM_DST && !s.skip) begin
                next_s.op = plmd_pkg::OP_FSM_DST;
              end
            end
            default: begin
              next_s.st = plmd_pkg::ST_FIRST;
            end
          endcase
        end
      end
      plmd_pkg::QTR_2: begin
        next_s.mem_rd = 1'b0;
        if (s.op == plmd_pkg::OP_RMOV || s.op == plmd_pkg::OP_FSM_SRC) begin
          next_s.data = mem_rdata;
        end
      end
      plmd_pkg::QTR_3: begin
        if (s.op == plmd_pkg::OP_RMOV && s.word[plmd_pkg::DEST_BIT]) begin
          next_s.mem_wr = 1'b1;
          next_s.mem_wdata = s.data;
        end
        if (s.op == plmd_pkg::OP_FSM_DST) begin
          // Second word only writes; the bus is not read again
          next_s.mem_addr = s.word[11:0];
          next_s.mem_wr = 1'b1;
          next_s.mem_wdata = s.data;
        end
      end
      plmd_pkg::QTR_4: begin
        next_s.mem_wr = 1'b0;
        case (s.op)
          plmd_pkg::OP_RMOV: begin
            if (!s.word[plmd_pkg::DEST_BIT]) begin
              next_s.wreg = s.data;
            end
            next_s.nf = s.data[7];
            next_s.zf = (s.data == 8'h00);
          end
          plmd_pkg::OP_PTR_HI: begin
            next_s.ptr[s.sel][11:8] = s.lit_hi;
          end
          plmd_pkg::OP_PTR_LO: begin
            next_s.ptr[s.sel][7:0] = s.word[7:0];
          end
          default: begin
            next_s.op = s.op;
          end
        endcase
      end
      default: begin
        next_s.q = plmd_pkg::QTR_1;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s <= '0;
      s.st <= plmd_pkg::ST_FIRST;
      s.op <= plmd_pkg::OP_NONE;
      s.ext <= plmd_pkg::RST_EXT;
      s.bank <= plmd_pkg::RST_BANK;
      s.wreg <= plmd_pkg::RST_WREG;
      s.ptr <= {3{plmd_pkg::RST_PTR}};
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign instr_ack     = s.instr_ack;
  assign mem_addr      = s.mem_addr;
  assign mem_rd        = s.mem_rd;
  assign mem_wr        = s.mem_wr;
  assign mem_wdata     = s.mem_wdata;
  assign wreg          = s.wreg;
  assign flag_negative = s.nf;
  assign flag_zero     = s.zf;
  assign ptr0          = s.ptr[0];
  assign ptr1          = s.ptr[1];
  assign ptr2          = s.ptr[2];
  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;

endmodule
`default_nettype wire

// >>> plmd_chk.sv
// Timing checker for the pointer load and move decoder.
// Assumes it is bound to plmd_top and that ce is high whenever strobes are judged.
`timescale 1ns/10ps
`default_nettype none
module plmd_chk (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        ce,
  input wire logic        instr_ack,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic        flag_negative,
  input wire logic        flag_zero,
  input wire logic [11:0] ptr0,
  input wire logic [11:0] ptr1,
  input wire logic [11:0] ptr2,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr
);
  // ****************************************************************
  // Quarter tracking and properties
  // ****************************************************************
  logic [1:0] qtr;
  always_ff @(posedge mclk) begin
    if (sys_rst) qtr <= 2'h0;
    else if (ce) qtr <= qtr + 2'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_rd_in_q2: assert property (mem_rd |-> qtr == plmd_pkg::QTR_2)
    else $error("read strobe outside the second quarter");
  a_wr_in_q4: assert property (mem_wr |-> qtr == plmd_pkg::QTR_4)
    else $error("write strobe outside the fourth quarter");
  a_ack_one_q2: assert property (instr_ack |-> qtr == plmd_pkg::QTR_2 ##1 !instr_ack)
    else $error("word acknowledge mistimed");
  // Pointers only move on a quarter four write, seen in the following first quarter
  a_ptr_at_q1: assert property ($changed({ptr0, ptr1, ptr2}) |-> qtr == plmd_pkg::QTR_1)
    else $error("pointer changed off the instruction boundary");
  a_flags_at_q1: assert property ($changed({flag_negative, flag_zero}) |-> qtr == 2'h0)
    else $error("flags changed off the instruction boundary");
  a_apb_no_wait: assert property (psel && !penable |=> pready)
    else $error("no ready in the access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error response without ready");
endmodule
`default_nettype wire

// >>> plmd_mem_model.sv
// Behavioural data memory standing behind the decoder.
// Assumes reads are combinational under the read strobe and writes land at the edge.
`timescale 1ns/10ps
`default_nettype none
module plmd_mem_model (
  input wire logic        mclk,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_rd,
  output logic     [7:0]  mem_rdata,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata
);
  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] mem [4096];
  logic [7:0] idle_pat;
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 37);
    idle_pat = 8'hA5;
  end
  // Toggling idle data stops a read outside the strobe from matching by luck
  always @(posedge mclk) begin
    idle_pat <= ~idle_pat;
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
  assign mem_rdata = mem_rd ? mem[mem_addr] : idle_pat;
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the pointer load and move decoder.
// Assumes the checker and the memory model are compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ****************************************************************
  // Signals, model state and tasks
  // ****************************************************************
  logic        mclk = 1'b0, sys_rst = 1'b1, ce = 1'b1, instr_valid = 1'b0, skip_exec = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [15:0] instr_word = 16'h0000;
  logic [11:0] paddr = 12'h000, mem_addr, ptr0, ptr1, ptr2;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'h0;
  logic [7:0]  mem_rdata, mem_wdata, wreg;
  logic        instr_ack, mem_rd, mem_wr, flag_negative, flag_zero, pready, pslverr;
  int          em [4096];
  int          ep [3];
  int          ew, en, ez, eb, ex, num_errors, checked;
  always #5 mclk = ~mclk;
  plmd_top i_plmd_top (.mclk, .sys_rst, .ce, .instr_word, .instr_valid, .skip_exec,
    .instr_ack, .mem_addr, .mem_rd, .mem_rdata, .mem_wr, .mem_wdata, .wreg,
    .flag_negative, .flag_zero, .ptr0, .ptr1, .ptr2, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);
  plmd_mem_model i_mem (.mclk, .mem_addr, .mem_rd, .mem_rdata, .mem_wr, .mem_wdata);
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Holds the word until it is taken, then runs out the instruction cycle
  task automatic issue(input logic [15:0] w, input logic sk);
    @(posedge mclk);
    instr_word <= w;
    instr_valid <= 1'b1;
    skip_exec <= sk;
    do @(posedge mclk); while (instr_ack !== 1'b1);
    instr_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic chk_ptrs;
    chk_val({20'h0, ptr0}, ep[0]);
    chk_val({20'h0, ptr1}, ep[1]);
    chk_val({20'h0, ptr2}, ep[2]);
  endtask
  task automatic pload(input int f, input int k);
    issue(16'(16'hE000 | f << 8 | k >> 8), 1'b0);
    if (f < 3) ep[f] = (ep[f] & 'hFF) | (k & 'hF00);
    chk_ptrs;
    issue(16'(16'hF000 | k & 'hFF), 1'b0);
    if (f < 3) ep[f] = k;
    chk_ptrs;
  endtask
  task automatic rmov(input int d, input int a, input int f);
    int ad, v;
    if (a) ad = eb * 256 + f;
    else if (ex && f <= 'h5F) ad = (ep[2] + f) & 'hFFF;
    else ad = (f < 'h80) ? f : 'hF00 + f;
    v = em[ad];
    if (d == 0) ew = v;
    en = v >> 7;
    ez = (v == 0);
    issue(16'(16'h5000 | d << 9 | a << 8 | f), 1'b0);
    chk_val({24'h0, wreg}, ew);
    chk_val({30'h0, flag_negative, flag_zero}, en * 2 + ez);
    chk_val({24'h0, i_mem.mem[ad]}, em[ad]);
  endtask
  task automatic fsm(input int s, input int t, input logic sk);
    issue(16'(16'hC000 | s), sk);
    // Five frozen clocks would slip the quarter phase if enable were ignored
    @(posedge mclk);
    ce <= 1'b0;
    repeat (5) @(posedge mclk);
    ce <= 1'b1;
    issue(16'(16'hF000 | t), 1'b0);
    if (!sk) em[t] = em[s];
    chk_val({24'h0, i_mem.mem[t]}, em[t]);
  endtask
  task automatic print_verdict;
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    print_verdict;
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    for (int i = 0; i < 4096; i++) em[i] = (i * 37) & 'hFF;
    void'($urandom(82908));
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk_val(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h500);
    eb = 5;
    apb(1'b0, 12'h018, 32'h0);
    chk_val({rd[30:0], er}, 32'h1);
    apb(1'b1, 12'h004, 32'h5A);
    ew = 'h5A;
    for (int f = 0; f < 4; f++) pload(f, 12'($urandom));
    chk_val({24'h0, wreg}, ew);
    rmov(0, 0, 'h00);
    rmov(0, 0, 'h85);
    rmov(0, 1, 'h10);
    rmov(1, 1, 'h20);
    apb(1'b1, 12'h000, 32'h501);
    ex = 1;
    rmov(0, 0, 'h10);
    rmov(0, 0, 'h5F);
    rmov(1, 0, 'h60);
    apb(1'b0, 12'h014, 32'h0);
    chk_val(rd, en * 2 + ez);
    // Destinations are random cells anywhere in the plain 4096-byte memory model
    for (int i = 0; i < 4; i++) fsm(12'($urandom), 12'($urandom), i == 3);
    print_verdict;
  end
endmodule
bind plmd_top plmd_chk i_chk (.mclk, .sys_rst, .ce, .instr_ack, .mem_rd, .mem_wr,
  .flag_negative, .flag_zero, .ptr0, .ptr1, .ptr2, .psel, .penable, .pready, .pslverr);
`default_nettype wire
